// file: tag_id_filter_append_tb.sv
// Self-checking bench for the tag filter with a queue-based model.
// Assumes tfa_filter and tfa_sink are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tag_id_filter_append_tb;
   typedef struct packed {
      logic [95:0] id;
      logic [1:0]  k;
      logic        a, p, t;
      logic [79:0] x;
   } tfa_exp_t;
   logic clk = 0, nrst = 0, cv = 0, dme = 0, nvl = 0, sa = 0, sb = 0, inv = 0;
   logic sort = 0, truck = 0, td = 0, octl = 0, tv = 0, hold = 0;
   logic [15:0] cc = 16'h0000;
   logic [8:0] nvd = 9'h000;
   logic [7:0] rid = 8'h3C;
   logic [95:0] tid = 96'h0;
   logic [95:0] nid;
   logic [1:0] tk = 2'h0;
   logic nvs, trdy, rvalid, rready, raux, rpage, rtd, relay;
   logic [8:0] setw;
   logic [95:0] rid_o;
   logic [1:0] rkind;
   logic [79:0] rtext;
   logic [95:0] hist [4];
   logic [3:0] hv = 4'h0;
   logic [95:0] run_id = 'x;
   logic aux = 0, pg = 0, xa = 0;
   logic [1:0] sep = 0, val = 0, tmo = 0;
   int seed = 32'h95D63B45;
   int run_len = 0, pcnt = 0, cyc = 0, last = 0, nrel = 0, erel = 0;
   int num_errors = 0, n_tests = 0;
   tfa_exp_t q [$];

   always #10 clk = ~clk;
   always @(posedge clk) cyc++;
   always @(posedge clk) if (relay === 1'b1) nrel++;

   tfa_filter #(.TICK_CYC(4)) tfa_filter_i (
      .sys_clk_i(clk), .nrst_i(nrst), .cmd_valid_i(cv), .cmd_code_i(cc),
      .data_mode_enter_i(dme), .nv_load_i(nvl), .nv_data_i(nvd), .nv_save_o(nvs),
      .settings_o(setw), .reader_ident_field_i(rid), .sensor_in_a_i(sa),
      .sensor_in_b_i(sb), .invert_inputs_i(inv), .multi_tag_sort_i(sort),
      .extended_truck_format_i(truck), .time_date_en_i(td), .output_ctl_i(octl),
      .tag_valid_i(tv), .tag_ready_o(trdy), .tag_id_i(tid), .tag_kind_i(tk),
      .rep_valid_o(rvalid), .rep_ready_i(rready), .rep_id_o(rid_o), .rep_kind_o(rkind),
      .rep_aux_o(raux), .rep_page_o(rpage), .rep_time_date_o(rtd),
      .rep_aux_text_o(rtext), .relay_pulse_o(relay));
   tfa_sink tfa_sink_i (.sys_clk_i(clk), .nrst_i(nrst), .hold_i(hold), .rep_ready_o(rready));

   task automatic chk_val(input string n, input logic [95:0] e, input logic [95:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic chk_rep(input tfa_exp_t e, input tfa_exp_t g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected report: expected %h, seen %h", e, g);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk) if (nrst && rvalid === 1'b1 && rready === 1'b1) begin
      tfa_exp_t e;
      e = q.size() ? q.pop_front() : '1;
      chk_rep(e, '{rid_o, rkind, raux, rpage, rtd, e.a ? rtext : 80'h0});
   end

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 10) ? 8'h30 + n : 8'h37 + n;
   endfunction

   task automatic cmd(input logic [15:0] c);
      cc = c;
      cv = 1;
      @(posedge clk);
      #1 cv = 0;
      if (c == 16'h0311 || c == 16'h0310) aux = c[0];
      if (c == 16'h0321 || c == 16'h0320) pg = c[0];
      if (c == 16'h0040) xa = 1;
      if (c[15:4] == 12'h410) begin
         sep = c[1:0];
         xa = 0;
      end
      if (c[15:4] == 12'h420) val = c[1:0];
      if (c[15:4] == 12'h044) begin
         hv = 0;
         run_len = 0;
         run_id = 'x;
         last = cyc;
         if (c[3:0] != 0) tmo = c[1:0] - 1;
      end
      chk_val("settings", {aux, pg, xa, sep, val, tmo}, setw);
      // Let an edge pass so that a following command raises cv afresh.
      @(posedge clk);
      #1;
   endtask

   task automatic send(input logic [95:0] id, input logic [1:0] k);
      logic ok, hit;
      tfa_exp_t e;
      int lim;
      tid = id;
      tk = k;
      tv = 1;
      {sort, truck, td, octl} = $random(seed);
      do begin
         ok = trdy;
         @(posedge clk);
         #1;
      end while (ok !== 1'b1);
      tv = 0;
      lim = tmo == 1 ? 60 : tmo == 2 ? 120 : 480;
      if (k == 2'd0 && id !== run_id) begin
         pcnt = run_len > 255 ? 255 : run_len;
         run_id = id;
         run_len = 0;
      end
      if (k == 2'd0) run_len++;
      e = '{id, k, aux && k != 2'd3, 1'b0, td,
            {8'h25, hx(rid[7:4]), hx(rid[3:0]), 8'h2D, 8'h30, 8'h2D,
             hx(pcnt[7:4]), hx(pcnt[3:0]), 8'h2D, 8'h30 + {6'h0, {sb, sa} ^ {2{inv}}}}};
      if (!e.a) e.x = 80'h0;
      if (k != 2'd0) q.push_back(e);
      else if (run_len > val) begin
         if (cyc - last > lim) hv = 0;
         hit = 0;
         for (int i = 0; i <= sep; i++) hit |= hv[i] && hist[i] === id;
         e.p = pg && sort && !truck;
         if (!hit) erel += octl;
         if (!hit || xa) q.push_back(e);
         for (int i = 3; i > 0; i--) hist[i] = hist[i-1];
         hist[0] = id;
         hv = {hv[2:0], 1'b1};
         last = cyc;
      end
      // The valid strobe stays low across one edge between two offers.
      @(posedge clk);
      #1;
   endtask

   task automatic drain;
      int i;
      for (i = 0; i < 400 && (q.size() != 0 || rvalid !== 1'b0); i++) @(posedge clk);
      #1 chk_val("pending", 96'h0, 96'(q.size()));
      chk_val("relay", 96'(erel), 96'(nrel));
   endtask

   task automatic mode_enter(input logic e);
      dme = 1;
      @(posedge clk);
      #1 dme = 0;
      chk_val("save", 96'(e), 96'(nvs));
      @(posedge clk);
      #1 chk_val("save end", 96'h0, 96'(nvs));
   endtask

   initial begin
      #(20 * 40000);
      num_errors++;
      give_verdict;
   end

   initial begin
      repeat (2) @(posedge clk);
      #1 chk_val("reset", 96'h2, {85'h0, setw, trdy, rvalid});
      nrst = 1;
      sa = 1;
      cmd(16'h0311);
      repeat (3) send(96'h1, 0);
      send(96'h2, 0);
      send(96'h0, 1);
      send(96'h0, 2);
      send(96'h0, 3);
      drain;
      inv = 1;
      sb = 1;
      repeat (4) @(posedge clk);
      #1 send(96'h0, 2);
      cmd(16'h0310);
      send(96'h0, 1);
      drain;
      cmd(16'h0321);
      for (int v = 0; v < 4; v++) for (int s = 0; s < 4; s++) begin
         cmd(16'h4200 + 16'(v));
         cmd(16'h4100 + 16'(s));
         repeat (12) begin
            nid = 96'($random(seed) & 3);
            repeat (($random(seed) & 3) + 1) send(nid, 0);
         end
      end
      drain;
      cmd(16'h4200);
      cmd(16'h0040);
      repeat (3) send(96'h7, 0);
      cmd(16'h4100);
      send(96'h7, 0);
      drain;
      cmd(16'h0442);
      send(96'h9, 0);
      repeat (40) @(posedge clk);
      #1 send(96'h9, 0);
      repeat (40) @(posedge clk);
      #1 send(96'h9, 0);
      repeat (100) @(posedge clk);
      #1 send(96'h9, 0);
      cmd(16'h0440);
      send(96'h9, 0);
      cmd(16'h0443);
      cmd(16'h0441);
      drain;
      cmd(16'h0040);
      hold = 1;
      for (int i = 0; i < 16; i++) send(96'(i + 16), 0);
      chk_val("ready full", 96'h0, 96'(trdy));
      hold = 0;
      drain;
      mode_enter(1);
      mode_enter(0);
      nvd = 9'h1A6;
      nvl = 1;
      @(posedge clk);
      #1 nvl = 0;
      chk_val("loaded", 96'h1A6, 96'(setw));
      give_verdict;
   end
endmodule
`default_nettype wire

// file: tfa_cfg.svh
// Constants for the tag identifier filter: option codes, reset values and timeouts.
// Assumes option codes arrive as BCD digit groups, right aligned in 16 bits.
//
// Contract
// - Auxiliary suffix starts off; option 311 turns it on, 310 turns it off.
// - Suffix goes on ID, presence and input-change reports, never on errors.
// - Suffix is percent, reader id, hyphen, antenna, hyphen, count, hyphen, input digit.
// - Antenna field of the suffix is always the digit zero.
// - Read count is two hex characters, 00 to FF, for the previous tag.
// - Input digit holds both sensor inputs, 0 to 3, inverted when inversion is on.
// - Extra page append starts off; option 321 enables it, 320 disables it.
// - Extra page covers tag bytes 10 to 17, only in ID-only mode with sort active.
// - Extra page follows the ID after an ampersand, before other suffixes.
// - Transmit-all mode skips the uniqueness check and reports every valid ID.
// - In transmit-all mode the output still fires once per valid unique ID.
// - Uniqueness separation is 1 to 4 IDs by options 4100-4103; default one.
// - Keep four latest IDs; report only if different from the first N entries.
// - Every newly acquired ID enters the comparison register, pass or fail.
// - A buffered ID is accepted again only after timeout or other IDs.
// - An ID is valid after 1 to 4 identical successive reads; default one.
// - Validation precedes uniqueness; failing IDs are never reported.
// - Reset-uniqueness command ends all timers and restarts filtering.
// - Timeout is two minutes by default, or 15 or 30 seconds by option.
// - Any timeout option expires the timer and clears the comparison register.
// - Timer stays reset while the same ID keeps arriving; else repeats each period.
// - Changed settings are saved to nonvolatile storage on entering data mode.
// - Time and date suffix is separated from the report by an ampersand.
`ifndef TFA_CFG_SVH
`define TFA_CFG_SVH

`define TFA_OPT_AUX_OFF     16'h0310
`define TFA_OPT_AUX_ON      16'h0311
`define TFA_OPT_PAGE_OFF    16'h0320
`define TFA_OPT_PAGE_ON     16'h0321
`define TFA_OPT_XMIT_ALL    16'h0040
`define TFA_OPT_SEP_BASE    16'h4100
`define TFA_OPT_VAL_BASE    16'h4200
`define TFA_OPT_UNIQ_RST    16'h0440
`define TFA_OPT_TMO_2MIN    16'h0441
`define TFA_OPT_TMO_15S     16'h0442
`define TFA_OPT_TMO_30S     16'h0443

`define TFA_CLK_PERIOD_NS   20
`define TFA_NS_PER_SEC      1000000000
`define TFA_TMO_2MIN_S      7'd120
`define TFA_TMO_15S_S       7'd15
`define TFA_TMO_30S_S       7'd30

`define TFA_PAGE_FIRST      8'h10
`define TFA_PAGE_LAST       8'h17
`define TFA_PAGE_BYTES      4'h8

`define TFA_CH_PERCENT      8'h25
`define TFA_CH_HYPHEN       8'h2D
`define TFA_CH_ZERO         8'h30
`define TFA_CH_AMP          8'h26
`define TFA_CH_HEX_ALPHA    8'h37

`define TFA_RST_SETTINGS    9'h000
`define TFA_CMP_DEPTH       4

`endif

// file: tfa_fifo.sv
// Synchronous FIFO of parameterised width and depth with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module tfa_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic         sys_clk_i,
   input  wire logic         nrst_i,
   // Fill side.
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side.
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   assign empty       = (wr_ptr == rd_ptr);
   assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign push        = in_valid_i && !full;
   assign pop         = out_ready_i && !empty;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

endmodule

`default_nettype wire

// file: tfa_filter.sv
// Tag identifier filter: validation, uniqueness, timeout and report suffix fields.
// Assumes option codes and tags come from logic on sys_clk_i; sensor inputs are pins.
`include "tfa_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tfa_filter #(
   parameter int ID_W     = 96,
   parameter int FIFO_DEP = 16,
   parameter int TICK_CYC = `TFA_NS_PER_SEC / `TFA_CLK_PERIOD_NS
) (
   // Clock and reset.
   input  wire logic            sys_clk_i,
   input  wire logic            nrst_i,
   // Option commands from the host parser.
   input  wire logic            cmd_valid_i,
   input  wire logic [15:0]     cmd_code_i,
   input  wire logic            data_mode_enter_i,
   // Nonvolatile storage of settings.
   input  wire logic            nv_load_i,
   input  wire logic [8:0]      nv_data_i,
   output logic                 nv_save_o,
   output logic [8:0]           settings_o,
   // Reader configuration and pins.
   input  wire logic [7:0]      reader_ident_field_i,
   input  wire logic            sensor_in_a_i,
   input  wire logic            sensor_in_b_i,
   input  wire logic            invert_inputs_i,
   input  wire logic            multi_tag_sort_i,
   input  wire logic            extended_truck_format_i,
   input  wire logic            time_date_en_i,
   input  wire logic            output_ctl_i,
   // Acquired tags and other reports.
   input  wire logic            tag_valid_i,
   output logic                 tag_ready_o,
   input  wire logic [ID_W-1:0] tag_id_i,
   input  wire logic [1:0]      tag_kind_i,
   // Reports towards the serial formatter.
   output logic                 rep_valid_o,
   input  wire logic            rep_ready_i,
   output logic [ID_W-1:0]      rep_id_o,
   output logic [1:0]           rep_kind_o,
   output logic                 rep_aux_o,
   output logic                 rep_page_o,
   output logic                 rep_time_date_o,
   output logic [79:0]          rep_aux_text_o,
   // Output relay.
   output logic                 relay_pulse_o
);
   localparam int RW = ID_W + 2 + 3 + 80;

   // Settings.
   logic       aux_en;
   logic       page_en;
   logic       xmit_all;
   logic [1:0] sep_sel;
   logic [1:0] val_sel;
   logic [1:0] tmo_sel;
   logic       dirty;

   // Filter state.
   logic [ID_W-1:0] cmp_id [`TFA_CMP_DEPTH];
   logic [3:0]      cmp_v;
   logic [ID_W-1:0] last_raw;
   logic            have_raw;
   logic [7:0]      run_cnt;
   logic [7:0]      prev_cnt;
   logic [25:0]     pre_cnt;
   logic [6:0]      sec_cnt;
   logic            sens_a_m;
   logic            sens_a;
   logic            sens_b_m;
   logic            sens_b;

   // Decision signals.
   logic            cmd_sep;
   logic            cmd_val;
   logic            cmd_tmo;
   logic            flush;
   logic            accept;
   logic            accept_id;
   logic            same_raw;
   logic [7:0]      next_run;
   logic            validated;
   logic [3:0]      hit;
   logic            match;
   logic            pass;
   logic            fifo_wr;
   logic            fifo_ready;
   logic            tick;
   logic            expire;
   logic [6:0]      tmo_lim;
   logic [1:0]      status_q;
   logic [7:0]      cnt_hi;
   logic [7:0]      cnt_lo;
   logic [7:0]      rid_hi;
   logic [7:0]      rid_lo;
   logic [79:0]     aux_text;
   logic            w_aux;
   logic            w_page;
   logic [RW-1:0]   w_data;
   logic [RW-1:0]   r_data;

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      if (n < 4'hA) begin
         hex_char = `TFA_CH_ZERO + {4'h0, n};
      end else begin
         hex_char = `TFA_CH_HEX_ALPHA + {4'h0, n};
      end
   endfunction

   assign cmd_sep = cmd_valid_i && (cmd_code_i[15:2] == `TFA_OPT_SEP_BASE >> 2);
   assign cmd_val = cmd_valid_i && (cmd_code_i[15:2] == `TFA_OPT_VAL_BASE >> 2);
   assign cmd_tmo = cmd_valid_i && ((cmd_code_i == `TFA_OPT_TMO_2MIN) ||
                                    (cmd_code_i == `TFA_OPT_TMO_15S)  ||
                                    (cmd_code_i == `TFA_OPT_TMO_30S));
   // A timeout selection throws away the stored IDs as well.
   assign flush   = (cmd_valid_i && (cmd_code_i == `TFA_OPT_UNIQ_RST)) || cmd_tmo;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {aux_en, page_en, xmit_all, sep_sel, val_sel, tmo_sel} <= `TFA_RST_SETTINGS;
      end else if (nv_load_i) begin
         {aux_en, page_en, xmit_all, sep_sel, val_sel, tmo_sel} <= nv_data_i;
      end else if (cmd_valid_i) begin
         if ((cmd_code_i == `TFA_OPT_AUX_ON) || (cmd_code_i == `TFA_OPT_AUX_OFF)) begin
            aux_en <= cmd_code_i[0];
         end
         if ((cmd_code_i == `TFA_OPT_PAGE_ON) || (cmd_code_i == `TFA_OPT_PAGE_OFF)) begin
            page_en <= cmd_code_i[0];
         end
         // Transmit-all stays on until a separation option reinstates the check.
         if (cmd_code_i == `TFA_OPT_XMIT_ALL) begin
            xmit_all <= 1'b1;
         end
         if (cmd_sep) begin
            xmit_all <= 1'b0;
            sep_sel  <= cmd_code_i[1:0];
         end
         if (cmd_val) begin
            val_sel <= cmd_code_i[1:0];
         end
         if (cmd_tmo) begin
            tmo_sel <= cmd_code_i[1:0] - 2'd1;
         end
      end
   end

   assign settings_o = {aux_en, page_en, xmit_all, sep_sel, val_sel, tmo_sel};

   // A change arriving with the save strobe stays dirty for the next save.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dirty     <= 1'b0;
         nv_save_o <= 1'b0;
      end else begin
         nv_save_o <= data_mode_enter_i && dirty;
         if (cmd_valid_i) begin
            dirty <= 1'b1;
         end else if (data_mode_enter_i || nv_load_i) begin
            dirty <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sens_a_m <= 1'b0;
         sens_a   <= 1'b0;
         sens_b_m <= 1'b0;
         sens_b   <= 1'b0;
      end else begin
         sens_a_m <= sensor_in_a_i;
         sens_a   <= sens_a_m;
         sens_b_m <= sensor_in_b_i;
         sens_b   <= sens_b_m;
      end
   end

   // One item per cycle; back-pressure from the FIFO stalls the source.
   assign tag_ready_o = fifo_ready;
   assign accept      = tag_valid_i && fifo_ready;
   assign accept_id   = accept && (tag_kind_i == tfa_pkg::TFA_KIND_ID);

   assign same_raw  = have_raw && (tag_id_i == last_raw);
   assign next_run  = !same_raw ? 8'h01 : ((run_cnt == 8'hFF) ? 8'hFF : run_cnt + 8'h01);
   assign validated = (next_run > {6'h00, val_sel});

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_raw <= '0;
         have_raw <= 1'b0;
         run_cnt  <= 8'h00;
         prev_cnt <= 8'h00;
      end else if (accept_id) begin
         last_raw <= tag_id_i;
         have_raw <= 1'b1;
         run_cnt  <= next_run;
         if (!same_raw) begin
            prev_cnt <= run_cnt;
         end
      end else if (flush) begin
         have_raw <= 1'b0;
         run_cnt  <= 8'h00;
      end
   end

   generate
      for (genvar i = 0; i < `TFA_CMP_DEPTH; i++) begin : g_cmp
         // Only the first N entries take part in the test.
         assign hit[i] = cmp_v[i] && (cmp_id[i] == tag_id_i) && (i <= sep_sel);
         if (i == 0) begin : g_head
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
               if (!nrst_i) begin
                  cmp_id[i] <= '0;
               end else if (accept_id && validated) begin
                  cmp_id[i] <= tag_id_i;
               end
            end
         end else begin : g_tail
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
               if (!nrst_i) begin
                  cmp_id[i] <= '0;
               end else if (accept_id && validated) begin
                  cmp_id[i] <= cmp_id[i-1];
               end
            end
         end
      end
   endgenerate

   assign match = |hit;
   assign pass  = !match;

   // A new ID after a flush is stored, with everything older forgotten.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmp_v <= 4'h0;
      end else if (accept_id && validated) begin
         cmp_v <= (flush || expire) ? 4'h1 : {cmp_v[2:0], 1'b1};
      end else if (flush || expire) begin
         cmp_v <= 4'h0;
      end
   end

   always_comb begin
      case (tmo_sel)
         tfa_pkg::TFA_TMO_15S: tmo_lim = `TFA_TMO_15S_S;
         tfa_pkg::TFA_TMO_30S: tmo_lim = `TFA_TMO_30S_S;
         default:              tmo_lim = `TFA_TMO_2MIN_S;
      endcase
   end

   assign tick   = (pre_cnt == 26'(TICK_CYC - 1));
   assign expire = tick && (sec_cnt == tmo_lim - 7'd1);

   // Every validated arrival restarts the clock, so a parked tag never repeats.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_cnt <= 26'h0000000;
         sec_cnt <= 7'h00;
      end else if (flush || (accept_id && validated) || expire) begin
         pre_cnt <= 26'h0000000;
         sec_cnt <= 7'h00;
      end else if (tick) begin
         pre_cnt <= 26'h0000000;
         sec_cnt <= sec_cnt + 7'd1;
      end else begin
         pre_cnt <= pre_cnt + 26'd1;
      end
   end

   // Validation gates ID reports only, other kinds pass straight in; transmit-all only bypasses uniqueness.
   assign fifo_wr = accept && (!accept_id || (validated && (pass || xmit_all)));

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         relay_pulse_o <= 1'b0;
      end else begin
         relay_pulse_o <= output_ctl_i && accept_id && validated && pass;
      end
   end

   assign status_q = {sens_b, sens_a} ^ {2{invert_inputs_i}};
   assign rid_hi   = hex_char(reader_ident_field_i[7:4]);
   assign rid_lo   = hex_char(reader_ident_field_i[3:0]);
   assign cnt_hi   = hex_char((accept_id && !same_raw) ? run_cnt[7:4] : prev_cnt[7:4]);
   assign cnt_lo   = hex_char((accept_id && !same_raw) ? run_cnt[3:0] : prev_cnt[3:0]);
   // Antenna digit is fixed; the formatter sends the bytes from the top down.
   assign aux_text = {`TFA_CH_PERCENT, rid_hi, rid_lo, `TFA_CH_HYPHEN, `TFA_CH_ZERO,
                      `TFA_CH_HYPHEN, cnt_hi, cnt_lo, `TFA_CH_HYPHEN,
                      `TFA_CH_ZERO + {6'h00, status_q}};

   assign w_aux  = aux_en && (tag_kind_i != tfa_pkg::TFA_KIND_ERROR);
   // The formatter sends ID, then ampersand and page, then time/date, then aux.
   assign w_page = page_en && accept_id && multi_tag_sort_i &&
                   !extended_truck_format_i;
   assign w_data = {tag_id_i, tag_kind_i, w_aux, w_page, time_date_en_i, aux_text};

   tfa_fifo #(
      .W     (RW),
      .DEPTH (FIFO_DEP)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (fifo_wr),
      .in_ready_o  (fifo_ready),
      .in_data_i   (w_data),
      .out_valid_o (rep_valid_o),
      .out_ready_i (rep_ready_i),
      .out_data_o  (r_data)
   );

   assign {rep_id_o, rep_kind_o, rep_aux_o, rep_page_o, rep_time_date_o, rep_aux_text_o} = r_data;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_flush_quiet;
      flush && !(accept_id && validated);
   endsequence
   sequence s_cmp_empty;
      cmp_v == 4'h0;
   endsequence
   sequence s_store;
      accept_id && validated;
   endsequence
   a_aux_on_cmd: assert property (
      cmd_valid_i && (cmd_code_i == `TFA_OPT_AUX_ON) && !nv_load_i |=> aux_en)
      else $error("aux option did not enable the suffix");
   a_no_err_aux: assert property (
      fifo_wr && (tag_kind_i == tfa_pkg::TFA_KIND_ERROR) |-> !w_aux)
      else $error("error report carries auxiliary suffix");
   a_aux_layout: assert property (
      fifo_wr |-> (w_data[79:72] == 8'h25) && (w_data[47:40] == 8'h30))
      else $error("suffix prefix or antenna digit wrong");
   a_page_gate: assert property (
      fifo_wr && w_page |-> multi_tag_sort_i && !extended_truck_format_i
                            && (tag_kind_i == tfa_pkg::TFA_KIND_ID))
      else $error("extra page flagged outside ID-only sort mode");
   a_dup_dropped: assert property (
      accept_id && validated && match && !xmit_all |-> !fifo_wr)
      else $error("duplicate ID passed uniqueness");
   a_xmit_all: assert property (
      accept_id && validated && xmit_all |-> fifo_wr)
      else $error("transmit-all dropped a valid ID");
   a_relay_once: assert property (
      relay_pulse_o |-> $past(pass) && $past(accept_id))
      else $error("relay fired for a non-unique ID");
   a_store_head: assert property (
      s_store |=> cmp_v[0] && (cmp_id[0] == $past(tag_id_i)))
      else $error("acquired ID not entered into comparison register");
   a_invalid_drop: assert property (
      accept_id && !validated |-> !fifo_wr)
      else $error("unvalidated ID reported");
   a_flush_clear: assert property (
      s_flush_quiet |=> s_cmp_empty)
      else $error("comparison register survived a flush");
   a_timer_hold: assert property (
      s_store |=> (sec_cnt == 7'h00) && (pre_cnt == 26'h0000000))
      else $error("timeout clock not held by an arriving ID");
   a_nv_save: assert property (
      data_mode_enter_i && dirty |=> nv_save_o)
      else $error("settings not saved on entering data mode");

endmodule

`default_nettype wire

// file: tfa_pkg.sv
// Types shared by the tag identifier filter.
// Assumes nothing beyond the constants header.
package tfa_pkg;

   typedef enum logic [1:0] {
      TFA_KIND_ID       = 2'b00,
      TFA_KIND_PRESENCE = 2'b01,
      TFA_KIND_INPUT    = 2'b10,
      TFA_KIND_ERROR    = 2'b11
   } tfa_kind_t;

   typedef enum logic [1:0] {
      TFA_TMO_2MIN = 2'b00,
      TFA_TMO_15S  = 2'b01,
      TFA_TMO_30S  = 2'b10
   } tfa_tmo_t;

endpackage

// file: tfa_sink.sv
// Report consumer standing in for the serial formatter.
// Assumes the bench clock and reset; hold_i stalls it completely.
`timescale 1ns/1ps
`default_nettype none
module tfa_sink (
   // Clock and reset.
   input  wire logic sys_clk_i,
   input  wire logic nrst_i,
   // Report handshake.
   input  wire logic hold_i,
   output logic      rep_ready_o
);
   int seed = 32'h95D63B45;
   // Random stalls show that a report stands until it is taken.
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) rep_ready_o <= 1'b0;
      else rep_ready_o <= #1 !hold_i && ($random(seed) % 4 != 0);
   end
endmodule
`default_nettype wire
